// ==== safety_pkg.sv ====
// shared constants, types and checksum functions for the safety link
// Overview of operation
// R1: controller refreshes telegrams before watchdog runs out
// R2: each valid telegram restarts the watchdog
// R3: watchdog period 10 to 10000 milliseconds
// R4: target address 1..255, equals switch
// R5: codename of origin and target authenticates link
// R6: controller origin address defaults to one
// R7: on error passivate outputs and report fault
// R8: passivated outputs carry zero substitute values
// R9: telegram checksum rejects bad data or addressing
// R10: telegram checksum length is three bytes
// R11: sequence number confirms order and completeness
// R12: requested integrity level must match local rating
// R13: parameter block type must be zero
// R14: parameter block version must be one
// R15: parameter signature verified on arrival
// R16: only common parameter block, no individual parameters
// R17: parameter fault cleared only by new block
// R18: runtime faults held until controller acknowledgment; a good new parameter block also clears them here
package safety_pkg;
   localparam int          MS_IN_NS          = 1000000;
   localparam int          CLK_NS            = 5;
   localparam int          CYCLES_PER_MS_DEF = MS_IN_NS / CLK_NS;
   localparam int          DATA_W            = 8;
   localparam int          SEQ_W             = 8;
   localparam int          WD_W              = 14;
   localparam int          SIG_W             = 16;
   localparam int          CHK_W             = 24;
   localparam int          FLT_W             = 4;
   localparam int          FLT_PARAM         = 0;
   localparam int          FLT_WD            = 1;
   localparam int          FLT_CHK           = 2;
   localparam int          FLT_SEQ           = 3;
   localparam logic [1:0]  RATED_LEVEL_DEF   = 2'h3;
   localparam logic [1:0]  CHK_LEN_BYTES     = 2'h3;
   localparam logic [2:0]  BLOCK_TYPE_PLAIN  = 3'h0;
   localparam logic [2:0]  PAR_VERSION_V2    = 3'h1;
   localparam logic [7:0]  ORIGIN_ADDR_DEF   = 8'h01;
   localparam logic [7:0]  ADDR_MIN          = 8'h01;
   localparam logic [13:0] WD_MIN            = 14'h000a;
   localparam logic [13:0] WD_MAX            = 14'h2710;
   localparam logic [15:0] SIG_SEED          = 16'ha5c3;
   localparam logic [23:0] CHK_SEED          = 24'h5a3c96;
   // register map of the controller
   localparam logic [7:0]  OFS_CTRL          = 8'h00;
   localparam logic [7:0]  OFS_PARAM         = 8'h04;
   localparam logic [7:0]  OFS_PARAM2        = 8'h08;
   localparam logic [7:0]  OFS_TXDATA        = 8'h0c;
   localparam logic [7:0]  OFS_INTERVAL      = 8'h10;
   localparam logic [7:0]  OFS_STATUS        = 8'h14;
   localparam logic [7:0]  OFS_IRQ_STAT      = 8'h18;
   localparam logic [7:0]  OFS_IRQ_MASK      = 8'h1c;
   localparam int          CMD_SEND_PARAM    = 0;
   localparam int          CMD_CYCLIC        = 1;
   localparam int          CMD_ACK           = 2;
   localparam int          CMD_SEND_TEL      = 3;
   localparam int          PAR_TARGET_LSB    = 0;
   localparam int          PAR_LEVEL_LSB     = 8;
   localparam int          PAR_WD_LSB        = 16;
   localparam int          P2_TYPE_LSB       = 0;
   localparam int          P2_VER_LSB        = 4;
   localparam int          P2_LEN_LSB        = 8;
   localparam int          P2_BAD_SIG        = 12;
   localparam int          IRQ_REPLY_OK      = 0;
   localparam int          IRQ_FAULT         = 1;
   localparam int          IRQ_W             = 2;
   localparam int          HTRANS_ACTIVE     = 1;
   localparam logic [31:0] PARAM_RST         = 32'h0096_0301;
   localparam logic [31:0] PARAM2_RST        = 32'h0000_0310;

   typedef struct packed {
      logic [7:0]  origin_addr;
      logic [7:0]  target_addr;
      logic [1:0]  requested_integrity_level;
      logic [1:0]  checksum_len;
      logic [2:0]  param_block_type;
      logic [2:0]  block_version;
      logic [13:0] safety_watchdog_period;
   } param_set_type;

   function automatic logic [15:0] param_sig(input param_set_type p);
      return p[15:0] ^ p[31:16] ^ {8'h00, p[39:32]} ^ SIG_SEED;
   endfunction : param_sig

   function automatic logic [23:0] tel_chk(input logic [7:0] data, seq, input logic ack,
                                          input logic [15:0] code, sig);
      return {code, sig[7:0]} ^ {sig[15:8], data, seq} ^ {23'h000000, ack} ^ CHK_SEED;
   endfunction : tel_chk
endpackage : safety_pkg

// ==== safety_link_if.sv ====
// link between safe controller and safety device
interface safety_link_if
   import safety_pkg::*;
   ();
   logic                param_valid;
   param_set_type       param;
   logic [SIG_W-1:0]    param_signature;
   logic                tel_valid;
   logic [DATA_W-1:0]   tel_data;
   logic [SEQ_W-1:0]    tel_seq;
   logic                tel_ack;
   logic [CHK_W-1:0]    telegram_checksum;
   logic                reply_valid;
   logic [FLT_W-1:0]    reply_faults;
   logic [SEQ_W-1:0]    reply_seq;

   modport device (
      input  param_valid, param, param_signature,
      input  tel_valid, tel_data, tel_seq, tel_ack, telegram_checksum,
      output reply_valid, reply_faults, reply_seq
   );
   modport controller (
      output param_valid, param, param_signature,
      output tel_valid, tel_data, tel_seq, tel_ack, telegram_checksum,
      input  reply_valid, reply_faults, reply_seq
   );
endinterface : safety_link_if

// ==== safety_device.sv ====
// safety device end: parameter check, watchdog, telegram check, passivation
module safety_device
   import safety_pkg::*;
   #(
      parameter int         CYCLES_PER_MS = CYCLES_PER_MS_DEF,
      parameter logic [1:0] RATED_LEVEL   = RATED_LEVEL_DEF
   )
   (
      input  wire logic              hclk,
      input  wire logic              hresetn,
      input  wire logic              clk_en,
      input  wire logic [7:0]        address_switch,
      safety_link_if.device          link,
      output logic [DATA_W-1:0]      safe_outputs,
      output logic                   passivated,
      output logic [FLT_W-1:0]       fault_flags,
      output logic                   param_loaded
   );

   typedef enum logic [1:0] {ST_WAIT_PARAM, ST_RUN, ST_PASSIVE} dev_state_type;

   localparam logic [31:0] DIV_LAST = 32'(CYCLES_PER_MS - 1);

   dev_state_type        state_reg;
   dev_state_type        state_next;
   logic [7:0]           sw_meta_reg;
   logic [7:0]           sw_sync_reg;
   param_set_type        cfg_reg;
   logic [SIG_W-1:0]     sig_reg;
   logic                 loaded_reg;
   logic                 resync_reg;
   logic [FLT_W-1:0]     faults_reg;
   logic [FLT_W-1:0]     faults_next;
   logic [SEQ_W-1:0]     exp_seq_reg;
   logic [31:0]          div_reg;
   logic [WD_W-1:0]      ms_reg;
   logic [DATA_W-1:0]    out_reg;
   logic [DATA_W-1:0]    out_next;
   logic                 reply_valid_reg;
   logic [FLT_W-1:0]     reply_faults_reg;
   logic [SEQ_W-1:0]     reply_seq_reg;

   wire logic [15:0]     codename;
   wire logic            p_addr_ok;
   wire logic            p_level_ok;
   wire logic            p_len_ok;
   wire logic            p_type_ok;
   wire logic            p_ver_ok;
   wire logic            p_wd_ok;
   wire logic            p_sig_ok;
   wire logic            param_good;
   wire logic            param_load_ok;
   wire logic            addr_lost;
   wire logic            tel_checked;
   wire logic            chk_good;
   wire logic            seq_good;
   wire logic            valid_tel;
   wire logic            ack_ok;
   wire logic            wd_tick;
   wire logic            wd_expire;
   wire logic            timer_hold;
   wire logic [FLT_W-1:0] fault_set;
   wire logic [FLT_W-1:0] fault_clr;

   // the switch is a pin; link inputs are on hclk
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sw_meta_reg <= 8'h00;
         sw_sync_reg <= 8'h00;
      end
      else if (clk_en)
      begin
         sw_meta_reg <= address_switch;
         sw_sync_reg <= sw_meta_reg;
      end
   end

   // parameter block checks
   assign p_addr_ok  = (link.param.target_addr >= ADDR_MIN)
                       && (link.param.target_addr == sw_sync_reg); // R4
   assign p_level_ok = link.param.requested_integrity_level == RATED_LEVEL; // R12
   assign p_len_ok   = link.param.checksum_len == CHK_LEN_BYTES; // R10
   // a nonzero type would carry individual parameters
   assign p_type_ok  = link.param.param_block_type == BLOCK_TYPE_PLAIN; // R13 R16
   assign p_ver_ok   = link.param.block_version == PAR_VERSION_V2; // R14
   assign p_wd_ok    = (link.param.safety_watchdog_period >= WD_MIN)
                       && (link.param.safety_watchdog_period <= WD_MAX); // R3
   assign p_sig_ok   = link.param_signature == param_sig(link.param); // R15
   assign param_good = p_addr_ok & p_level_ok & p_len_ok & p_type_ok
                       & p_ver_ok & p_wd_ok & p_sig_ok;
   assign param_load_ok = link.param_valid & param_good;

   // switch moved after a good load: connection no longer authentic
   assign addr_lost = loaded_reg & ~link.param_valid
                      & (cfg_reg.target_addr != sw_sync_reg); // R4

   // telegram checks against the stored session
   assign codename    = {cfg_reg.origin_addr, cfg_reg.target_addr}; // R5
   assign tel_checked = link.tel_valid & loaded_reg & ~faults_reg[FLT_PARAM];
   assign chk_good    = link.telegram_checksum
                        == tel_chk(link.tel_data, link.tel_seq, link.tel_ack,
                                   codename, sig_reg); // R9 R10
   assign seq_good    = link.tel_seq == exp_seq_reg; // R11
   // ack or first telegram after a load resyncs the sequence
   assign valid_tel   = tel_checked & chk_good & (seq_good | link.tel_ack | resync_reg);
   assign ack_ok      = valid_tel & link.tel_ack; // R18

   // watchdog in whole milliseconds
   assign wd_tick    = div_reg == DIV_LAST; // R3
   assign wd_expire  = (state_reg == ST_RUN) & wd_tick & ~valid_tel
                       & (ms_reg == cfg_reg.safety_watchdog_period - 14'h0001); // R1
   assign timer_hold = valid_tel | (state_reg != ST_RUN); // R2

   // set wins over clear for every fault flag
   assign fault_set[FLT_PARAM] = (link.param_valid & ~param_good) | addr_lost;
   assign fault_set[FLT_WD]    = wd_expire; // R1
   assign fault_set[FLT_CHK]   = tel_checked & ~chk_good; // R9
   assign fault_set[FLT_SEQ]   = tel_checked & chk_good & ~seq_good
                                 & ~link.tel_ack & ~resync_reg; // R11
   // operator acknowledgment never clears a parameter fault
   assign fault_clr[FLT_PARAM] = param_load_ok; // R17
   assign fault_clr[FLT_SEQ:FLT_WD] = {(FLT_W-1){ack_ok | param_load_ok}}; // R18
   assign faults_next = (faults_reg & ~fault_clr) | fault_set; // R7

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         ST_WAIT_PARAM:
         begin
            if (param_load_ok && !fault_set[FLT_PARAM])
               state_next = ST_RUN;
         end
         ST_RUN:
         begin
            if (faults_next[FLT_PARAM])
               state_next = ST_WAIT_PARAM;
            else if (|faults_next)
               state_next = ST_PASSIVE; // R7
         end
         ST_PASSIVE:
         begin
            if (faults_next[FLT_PARAM])
               state_next = ST_WAIT_PARAM;
            else if (~|faults_next)
               state_next = ST_RUN; // R18
         end
         default:
            state_next = ST_WAIT_PARAM;
      endcase
   end

   // zero substitute values whenever not running
   assign out_next = (state_next != ST_RUN) ? '0 :
                     valid_tel ? link.tel_data : out_reg; // R8

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state_reg   <= ST_WAIT_PARAM;
         faults_reg  <= '0;
         out_reg     <= '0;
         cfg_reg     <= '0;
         sig_reg     <= '0;
         loaded_reg  <= 1'b0;
         resync_reg  <= 1'b0;
         exp_seq_reg <= '0;
      end
      else if (clk_en)
      begin
         state_reg  <= state_next;
         faults_reg <= faults_next;
         out_reg    <= out_next;
         if (param_load_ok)
         begin
            cfg_reg    <= link.param;
            sig_reg    <= link.param_signature;
            loaded_reg <= 1'b1;
            resync_reg <= 1'b1;
         end
         else if (valid_tel)
            resync_reg <= 1'b0;
         if (valid_tel)
            exp_seq_reg <= link.tel_seq + 8'h01; // R11
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         div_reg <= '0;
         ms_reg  <= '0;
      end
      else if (clk_en)
      begin
         if (timer_hold)
         begin
            div_reg <= '0; // R2
            ms_reg  <= '0; // R2
         end
         else if (wd_tick)
         begin
            div_reg <= '0;
            ms_reg  <= ms_reg + 14'h0001;
         end
         else
            div_reg <= div_reg + 32'h0000_0001;
      end
   end

   // every telegram and block gets the fault picture
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         reply_valid_reg  <= 1'b0;
         reply_faults_reg <= '0;
         reply_seq_reg    <= '0;
      end
      else if (clk_en)
      begin
         reply_valid_reg  <= link.tel_valid | link.param_valid; // R7
         reply_faults_reg <= faults_next; // R7
         if (link.tel_valid)
            reply_seq_reg <= link.tel_seq;
      end
   end

   assign link.reply_valid  = reply_valid_reg;
   assign link.reply_faults = reply_faults_reg;
   assign link.reply_seq    = reply_seq_reg;
   assign safe_outputs      = out_reg;
   assign passivated        = state_reg != ST_RUN;
   assign fault_flags       = faults_reg;
   assign param_loaded      = loaded_reg;

endmodule : safety_device

// ==== safety_controller.sv ====
// safe controller end: AHB-Lite registers, parameter and telegram sender
module safety_controller
   import safety_pkg::*;
   #(
      parameter logic [7:0] ORIGIN_ADDR = ORIGIN_ADDR_DEF
   )
   (
      input  wire logic          hclk,
      input  wire logic          hresetn,
      input  wire logic          clk_en,
      input  wire logic          hsel,
      input  wire logic [31:0]   haddr,
      input  wire logic [1:0]    htrans,
      input  wire logic          hwrite,
      input  wire logic [2:0]    hsize,
      input  wire logic [31:0]   hwdata,
      input  wire logic          hready,
      output logic               hreadyout,
      output logic               hresp,
      output logic [31:0]        hrdata,
      output logic               irq,
      safety_link_if.controller  link
   );

   logic                 dp_valid_reg;
   logic                 dp_write_reg;
   logic [7:0]           dp_addr_reg;
   logic                 rd_done_reg;
   logic [31:0]          hrdata_reg;
   logic [31:0]          param_reg;
   logic [31:0]          param2_reg;
   logic [DATA_W-1:0]    txdata_reg;
   logic [31:0]          interval_reg;
   logic [31:0]          gap_reg;
   logic                 cyclic_reg;
   logic                 ack_pend_reg;
   logic [SEQ_W-1:0]     seq_reg;
   logic [IRQ_W-1:0]     irq_stat_reg;
   logic [IRQ_W-1:0]     irq_mask_reg;
   logic [FLT_W-1:0]     last_faults_reg;
   logic [SEQ_W-1:0]     last_seq_reg;
   logic                 pv_reg;
   param_set_type        pblk_reg;
   logic [SIG_W-1:0]     psig_reg;
   logic                 tv_reg;
   logic [DATA_W-1:0]    tdata_reg;
   logic [SEQ_W-1:0]     tseq_reg;
   logic                 tack_reg;
   logic [CHK_W-1:0]     tchk_reg;

   wire logic            accept;
   wire logic            send_param;
   wire logic            tel_fire;
   wire logic            ack_req;
   wire logic [31:0]     rd_word;
   wire param_set_type   pb;
   wire logic [IRQ_W-1:0] irq_set;

   function automatic logic wr_sel(input logic [7:0] ofs);
      return dp_valid_reg & dp_write_reg & (dp_addr_reg == ofs);
   endfunction : wr_sel

   // writes take no wait state, reads one for a registered hrdata
   assign accept    = hsel & hready & htrans[HTRANS_ACTIVE];
   assign hreadyout = ~(dp_valid_reg & ~dp_write_reg & ~rd_done_reg);
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_reg;

   assign rd_word = (dp_addr_reg == OFS_CTRL)     ? {30'h0, cyclic_reg, 1'b0} :
                    (dp_addr_reg == OFS_PARAM)    ? param_reg :
                    (dp_addr_reg == OFS_PARAM2)   ? param2_reg :
                    (dp_addr_reg == OFS_TXDATA)   ? {24'h0, txdata_reg} :
                    (dp_addr_reg == OFS_INTERVAL) ? interval_reg :
                    (dp_addr_reg == OFS_STATUS)   ? {16'h0, last_seq_reg, 4'h0, last_faults_reg} :
                    (dp_addr_reg == OFS_IRQ_STAT) ? {30'h0, irq_stat_reg} :
                    (dp_addr_reg == OFS_IRQ_MASK) ? {30'h0, irq_mask_reg} : 32'h0;

   assign send_param = wr_sel(OFS_CTRL) & hwdata[CMD_SEND_PARAM];
   assign ack_req    = wr_sel(OFS_CTRL) & hwdata[CMD_ACK];
   // software picks the interval below the device watchdog period
   assign tel_fire   = (wr_sel(OFS_CTRL) & hwdata[CMD_SEND_TEL])
                       | (cyclic_reg & (gap_reg == 32'h0)); // R1

   assign pb.origin_addr               = ORIGIN_ADDR; // R6
   assign pb.target_addr               = param_reg[PAR_TARGET_LSB +: 8];
   assign pb.requested_integrity_level = param_reg[PAR_LEVEL_LSB +: 2];
   assign pb.safety_watchdog_period    = param_reg[PAR_WD_LSB +: WD_W];
   assign pb.param_block_type          = param2_reg[P2_TYPE_LSB +: 3];
   assign pb.block_version             = param2_reg[P2_VER_LSB +: 3];
   assign pb.checksum_len              = param2_reg[P2_LEN_LSB +: 2];

   assign irq_set[IRQ_REPLY_OK] = link.reply_valid & ~|link.reply_faults;
   assign irq_set[IRQ_FAULT]    = link.reply_valid & |link.reply_faults;
   assign irq = |(irq_stat_reg & irq_mask_reg);

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dp_valid_reg <= 1'b0;
         dp_write_reg <= 1'b0;
         dp_addr_reg  <= 8'h00;
         rd_done_reg  <= 1'b0;
         hrdata_reg   <= 32'h0;
      end
      else if (clk_en)
      begin
         if (accept)
         begin
            dp_valid_reg <= 1'b1;
            dp_write_reg <= hwrite;
            dp_addr_reg  <= {haddr[7:2], 2'b00};
            rd_done_reg  <= 1'b0;
         end
         else if (hreadyout)
         begin
            dp_valid_reg <= 1'b0;
            rd_done_reg  <= 1'b0;
         end
         else
         begin
            rd_done_reg <= 1'b1;
            hrdata_reg  <= rd_word;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         param_reg    <= PARAM_RST;
         param2_reg   <= PARAM2_RST;
         txdata_reg   <= '0;
         interval_reg <= 32'h0;
         cyclic_reg   <= 1'b0;
         irq_mask_reg <= '0;
         irq_stat_reg <= '0;
      end
      else if (clk_en)
      begin
         if (wr_sel(OFS_PARAM))
            param_reg <= hwdata;
         if (wr_sel(OFS_PARAM2))
            param2_reg <= hwdata;
         if (wr_sel(OFS_TXDATA))
            txdata_reg <= hwdata[DATA_W-1:0];
         if (wr_sel(OFS_INTERVAL))
            interval_reg <= hwdata;
         if (wr_sel(OFS_CTRL))
            cyclic_reg <= hwdata[CMD_CYCLIC];
         if (wr_sel(OFS_IRQ_MASK))
            irq_mask_reg <= hwdata[IRQ_W-1:0];
         // an event in the clearing cycle survives
         irq_stat_reg <= (irq_stat_reg & ~(wr_sel(OFS_IRQ_STAT) ? hwdata[IRQ_W-1:0] : '0))
                         | irq_set;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         gap_reg         <= 32'h0;
         ack_pend_reg    <= 1'b0;
         seq_reg         <= '0;
         pv_reg          <= 1'b0;
         pblk_reg        <= '0;
         psig_reg        <= '0;
         tv_reg          <= 1'b0;
         tdata_reg       <= '0;
         tseq_reg        <= '0;
         tack_reg        <= 1'b0;
         tchk_reg        <= '0;
         last_faults_reg <= '0;
         last_seq_reg    <= '0;
      end
      else if (clk_en)
      begin
         pv_reg       <= send_param;
         tv_reg       <= tel_fire;
         ack_pend_reg <= (ack_pend_reg | ack_req) & ~tel_fire; // R18
         if (tel_fire)
            gap_reg <= interval_reg;
         else if (cyclic_reg)
            gap_reg <= gap_reg - 32'h1;
         if (send_param)
         begin
            pblk_reg <= pb;
            psig_reg <= param_sig(pb) ^ {15'h0, param2_reg[P2_BAD_SIG]}; // R15
         end
         if (tel_fire)
         begin
            tdata_reg <= txdata_reg;
            tseq_reg  <= seq_reg;
            tack_reg  <= ack_pend_reg | ack_req;
            tchk_reg  <= tel_chk(txdata_reg, seq_reg, ack_pend_reg | ack_req,
                                 {ORIGIN_ADDR, pblk_reg.target_addr}, psig_reg); // R9 R10
            seq_reg   <= seq_reg + 8'h01; // R11
         end
         if (link.reply_valid)
         begin
            last_faults_reg <= link.reply_faults;
            last_seq_reg    <= link.reply_seq;
         end
      end
   end

   assign link.param_valid       = pv_reg;
   assign link.param             = pblk_reg;
   assign link.param_signature   = psig_reg;
   assign link.tel_valid         = tv_reg;
   assign link.tel_data          = tdata_reg;
   assign link.tel_seq           = tseq_reg;
   assign link.tel_ack           = tack_reg;
   assign link.telegram_checksum = tchk_reg;

endmodule : safety_controller

// ==== safety_link_assertions.sv ====
// concurrent checks on the safety link between the two ends
module safety_link_assertions
   import safety_pkg::*;
   (
      input wire logic             hclk,
      input wire logic             hresetn,
      input wire logic             param_valid,
      input wire param_set_type    param,
      input wire logic [SIG_W-1:0] param_signature,
      input wire logic             tel_valid,
      input wire logic             tel_ack,
      input wire logic [SEQ_W-1:0] tel_seq,
      input wire logic             reply_valid,
      input wire logic [FLT_W-1:0] reply_faults,
      input wire logic [SEQ_W-1:0] reply_seq
   );
   timeunit 1ns;
   timeprecision 1ps;
   wire logic rejected = reply_faults[FLT_PARAM];
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_block_reply: assert property (param_valid |=> reply_valid)
      else $error("no block reply");
   a_tel_reply: assert property (tel_valid |=> reply_valid)
      else $error("no telegram reply");
   a_seq_echo: assert property (tel_valid |=> reply_seq == $past(tel_seq))
      else $error("reply seq wrong");
   a_target_zero: assert property (param_valid && param.target_addr == 8'h00 |=> rejected)
      else $error("zero target taken");
   a_level_check: assert property (
      param_valid && param.requested_integrity_level != RATED_LEVEL_DEF |=> rejected)
      else $error("level taken");
   a_len_check: assert property (
      param_valid && param.checksum_len != CHK_LEN_BYTES |=> rejected)
      else $error("length taken");
   a_type_version: assert property (
      param_valid && (param.param_block_type != BLOCK_TYPE_PLAIN
                      || param.block_version != PAR_VERSION_V2) |=> rejected)
      else $error("type or version taken");
   a_sig_check: assert property (
      param_valid && param_signature != param_sig(param) |=> rejected)
      else $error("bad signature taken");
   a_wd_range: assert property (
      param_valid && (param.safety_watchdog_period < WD_MIN
                      || param.safety_watchdog_period > WD_MAX) |=> rejected)
      else $error("period taken");
   a_param_sticky: assert property ($fell(reply_faults[FLT_PARAM]) |-> $past(param_valid))
      else $error("parameter fault cleared without block");
   cover property (tel_valid && tel_ack);
   cover property (reply_valid && reply_faults[FLT_WD]);
   cover property (reply_valid && reply_faults[FLT_PARAM]);
endmodule : safety_link_assertions

// ==== tb.sv ====
// bench joining controller and device over the safety link
module tb import safety_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [63:0] GOOD = {32'h000a_0305, 32'h0000_0310};
   logic        hclk = 0;
   logic        hresetn = 0;
   logic [31:0] haddr = 0, hwdata = 0, rdv, hrdata;
   logic [7:0]  sw = 8'h05;
   logic [1:0]  htrans = 0;
   logic        hwrite = 0;
   logic        hreadyout, hresp, irq, passivated, param_loaded;
   logic [7:0]  safe_outputs;
   logic [3:0]  fault_flags;
   int          num_errors = 0, cmp_count = 0, cyc = 0;
   // each block carries one flaw
   logic [63:0] bad [9] = '{{32'h000a_0300, 32'h310}, {32'h000a_0306, 32'h310},
      {32'h000a_0205, 32'h310}, {32'h000a_0305, 32'h210}, {32'h000a_0305, 32'h311},
      {32'h000a_0305, 32'h320}, {32'h0009_0305, 32'h310}, {32'h2711_0305, 32'h310},
      {32'h000a_0305, 32'h1310}};
   always #2.5 hclk = ~hclk;
   safety_link_if link ();
   safety_device #(.CYCLES_PER_MS(10)) u_safety_device (.hclk(hclk), .hresetn(hresetn),
      .clk_en(1'b1), .address_switch(sw), .link(link), .safe_outputs(safe_outputs),
      .passivated(passivated), .fault_flags(fault_flags), .param_loaded(param_loaded));
   safety_controller u_safety_controller (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1),
      .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .irq(irq), .link(link));
   safety_link_assertions u_safety_link_assertions (.hclk(hclk), .hresetn(hresetn),
      .param_valid(link.param_valid), .param(link.param), .param_signature(link.param_signature),
      .tel_valid(link.tel_valid), .tel_ack(link.tel_ack), .tel_seq(link.tel_seq),
      .reply_valid(link.reply_valid), .reply_faults(link.reply_faults), .reply_seq(link.reply_seq));
   task automatic give_verdict();
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : give_verdict
   task automatic chk(input string n, input logic [31:0] s, e);
      cmp_count++;
      if (s !== e)
      begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   // call just after a rising edge; the slave sets the wait states
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      haddr <= 32'(a);
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rdv = hrdata;
   endtask : bus
   task automatic tel(input logic [31:0] c);
      bus(1'b1, OFS_CTRL, c);
      for (int i = 0; i < 40 && link.reply_valid !== 1'b1; i++) @(posedge hclk);
      @(posedge hclk);
   endtask : tel
   task automatic load(input logic [63:0] p);
      bus(1'b1, OFS_PARAM, p[63:32]);
      bus(1'b1, OFS_PARAM2, p[31:0]);
      tel(32'h1);
   endtask : load
   always @(posedge hclk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         num_errors++;
         give_verdict();
      end
   end
   initial
   begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      chk("passive", {hresp, passivated}, 1);
      bus(1'b0, OFS_PARAM, 0);
      chk("param", rdv, PARAM_RST);
      bus(1'b0, OFS_PARAM2, 0);
      chk("param2", rdv, PARAM2_RST);
      bus(1'b0, 8'h20, 0);
      chk("unmapped", rdv, 0);
      load(GOOD);
      chk("loaded", {fault_flags, param_loaded, passivated}, 6'h02);
      bus(1'b1, OFS_TXDATA, 32'h3c);
      tel(32'h8);
      chk("outputs", safe_outputs, 8'h3c);
      repeat (98) @(posedge hclk);
      chk("wd early", fault_flags, 0);
      repeat (1) @(posedge hclk);
      chk("wd late", {fault_flags, safe_outputs, passivated}, {4'h2, 8'h00, 1'b1});
      tel(32'h8);
      bus(1'b0, OFS_STATUS, 0);
      chk("status", rdv[3:0], 4'h2);
      tel(32'hc);
      chk("ack", {fault_flags, safe_outputs}, 12'h03c);
      for (int k = 0; k < 9; k++)
      begin
         load(bad[k]);
         chk("reject", {fault_flags[0], safe_outputs}, 9'h100);
         tel(32'hc);
         chk("no ack clear", fault_flags[0], 1);
         load(GOOD);
         chk("reload", fault_flags, 0);
      end
      @(posedge hclk);
      chk("masked", irq, 0);
      bus(1'b1, OFS_IRQ_MASK, 32'h2);
      @(posedge hclk);
      chk("irq", irq, 1);
      bus(1'b1, OFS_IRQ_STAT, 32'h3);
      @(posedge hclk);
      chk("cleared", irq, 0);
      sw <= 8'h06;
      repeat (4) @(posedge hclk);
      chk("switch moved", {fault_flags[0], passivated}, 2'h3);
      give_verdict();
   end
endmodule : tb
